// File: src/fos_pkg.sv
// Constants and carriers for the serial flash OTP, power-down and quad program sequencer.
// Assumes one system clock far faster than the serial link clock.
// Notes on behaviour
// - Quad program needs write enable latch and quad enable
// - Quad program address and data on four lines
// - Protected page program is refused
// - Three-byte addressing default; four-byte mode extends
// - Quad program accepted only in single-line mode
// - Opcodes: eight SPI clocks or two QUAD_COMMAND_MODE clocks
// - Power-down only if deselect after eighth bit
// - Entry delay before low-power state
// - In power-down only release, signature, reset accepted
// - Software reset ends power-down; start in standby
// - OTP enter redirects read and program to OTP
// - Locked OTP accepts only read-type commands; the sequencer refuses only quad program there
// - OTP exit returns to main array
// - Security read works anytime outside power-down, repeats continuously
// - Security write: write enable, byte boundary, bit1 only
// - Lock-down bit once set never changes
// - Erase fail flag bit6 reflects last erase
// - Program fail flag bit5 reflects last program
// - Erase suspended flag bit3 set/cleared, default zero
// - Program suspended flag bit2 set/cleared, default zero
// - Bit0 factory lock; bits 7 and 4 reserved
// - Page program keeps last 256 bytes, wraps page
// - Program cycle starts at deselect; busy, then clear
package fos_pkg;
  localparam logic [7:0] OP_QUAD_PP = 8'h38;
  localparam logic [7:0] OP_QUAD_PP4B = 8'h3E;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_DEEP_PD = 8'hB9;
  localparam logic [7:0] OP_RELEASE_PD = 8'hAB;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
  localparam logic [7:0] OP_EXIT_OTP = 8'hC1;
  localparam logic [7:0] OP_READ_SEC = 8'h2B;
  localparam logic [7:0] OP_WRITE_SEC = 8'h2F;
  localparam int BIT_FACTORY = 0;
  localparam int BIT_LOCK = 1;
  localparam int BIT_PSUSP = 2;
  localparam int BIT_ESUSP = 3;
  localparam int BIT_PFAIL = 5;
  localparam int BIT_EFAIL = 6;
  localparam logic [7:0] SEC_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PD_ENTRY_NS = 10000;
  localparam int PD_ENTRY_CYC = PD_ENTRY_NS / CLK_PERIOD_NS;
  localparam int PROG_CYCLE_NS = 1500000;
  localparam int PROG_CYCLE_CYC = PROG_CYCLE_NS / CLK_PERIOD_NS;
  localparam int PAGE_BYTES = 256;
  localparam int OTP_BYTES = 512;

  typedef struct packed {
    logic [3:0] ioIn;
    logic sclk;
    logic csN;
  } fos_link_s;

  typedef struct packed {
    logic eraseDone;
    logic eraseFail;
    logic eraseSuspend;
    logic eraseResume;
    logic progSuspend;
    logic progResume;
  } fos_core_evt_s;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR = 7'h04,
    ST_DATA = 7'h08,
    ST_READOUT = 7'h10,
    ST_SWALLOW = 7'h20,
    ST_DONE = 7'h40
  } fos_frame_e;
endpackage

// File: src/fos_link_sync.sv
// Two-stage synchroniser and edge finder for the serial link pins.
// Assumes link clock well below sys_clk / 4.
`timescale 1ns/1ps
`default_nettype none
module fos_link_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw pins
  input wire fos_pkg::fos_link_s pinIn,
  // Synchronised view
  output fos_pkg::fos_link_s linkSync,
  output logic sclkRise,
  output logic sclkFall,
  output logic csRise,
  output logic csFall
);
  fos_pkg::fos_link_s stage1;
  fos_pkg::fos_link_s stage2;
  fos_pkg::fos_link_s stage3;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '{ioIn: 4'h0, sclk: 1'b0, csN: 1'b1};
      stage2 <= '{ioIn: 4'h0, sclk: 1'b0, csN: 1'b1};
      stage3 <= '{ioIn: 4'h0, sclk: 1'b0, csN: 1'b1};
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign linkSync = stage2;
  assign sclkRise = stage2.sclk & ~stage3.sclk;
  assign sclkFall = ~stage2.sclk & stage3.sclk;
  assign csRise = stage2.csN & ~stage3.csN;
  assign csFall = ~stage2.csN & stage3.csN;
endmodule
`default_nettype wire

// File: src/fos_sequencer.sv
// Command sequencer for quad program, deep power-down, OTP mode and security register.
// Assumes host drives mode 0 SPI; the array core reports erase and suspend events.
`timescale 1ns/1ps
`default_nettype none
module fos_sequencer #(
  parameter int PD_ENTRY_CYCLES = fos_pkg::PD_ENTRY_CYC,
  parameter int PROG_CYCLES = fos_pkg::PROG_CYCLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOeN,
  // Configuration and events from elsewhere in the device
  input wire logic quadEnable,
  input wire logic quadCmdMode,
  input wire logic fourByteMode,
  input wire logic [7:0] extAddrReg,
  input wire logic [3:0] blockProtect,
  input wire logic factoryLock,
  input wire logic lockNvIn,
  input wire logic writeEnableSet,
  input wire fos_pkg::fos_core_evt_s coreEvt,
  // State to the rest of the device
  output logic writeEnableLatch,
  output logic writeInProgress,
  output logic deepPowerDown,
  output logic otpMode,
  output logic [7:0] securityStatus,
  output logic progStart,
  output logic [31:0] progAddr,
  output logic progProtected
);
  fos_pkg::fos_link_s pinIn;
  fos_pkg::fos_link_s link;
  logic sclkRise;
  logic sclkFall;
  logic csRise;
  logic csFall;

  assign pinIn = '{ioIn: ioIn, sclk: sclk, csN: csN};

  fos_link_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pinIn(pinIn),
    .linkSync(link),
    .sclkRise(sclkRise),
    .sclkFall(sclkFall),
    .csRise(csRise),
    .csFall(csFall)
  );

  fos_pkg::fos_frame_e state;
  logic [7:0] opcode;
  logic [7:0] shiftIn;
  logic [5:0] bitCnt;
  logic [31:0] addr;
  logic [7:0] byteIdx;
  logic [8:0] byteCount;
  logic [7:0] pageBuf [0:fos_pkg::PAGE_BYTES-1];
  logic [7:0] otpMem [0:fos_pkg::OTP_BYTES-1];
  logic [7:0] outShift;
  logic readActive;
  logic resetArmed;
  logic pdPending;
  logic [31:0] pdCnt;
  logic [31:0] progCnt;
  logic progIsOtp;
  logic lockBit;
  logic lockCaught;
  logic progFail;
  logic eraseFail;
  logic progSusp;
  logic eraseSusp;
  logic [2:0] nibStep;
  logic [5:0] addrBits;

  // Bits per clock: four in quad command mode, else one
  function automatic logic [2:0] stepOf(input logic quad);
    stepOf = quad ? 3'h4 : 3'h1;
  endfunction

  // Page lies inside the protected region (top-down, count from BP value)
  function automatic logic isProtected(input logic [31:0] a, input logic [3:0] bp);
    logic [31:0] top;
    top = 32'h0;
    if (bp != 4'h0) begin
      top = 32'h01FF_FFFF - ((32'h0000_FFFF + 32'h1) << (bp - 4'h1)) + 32'h1;
    end
    isProtected = (bp == 4'hF) || ((bp != 4'h0) && (a[24:0] >= top[24:0]));
  endfunction

  assign nibStep = (state == fos_pkg::ST_OPCODE) ? stepOf(quadCmdMode) : 3'h4;
  assign addrBits = fourByteMode ? 6'd32 : 6'd24;

  logic [7:0] nextShift;
  always_comb begin
    nextShift = (nibStep == 3'h4) ? {shiftIn[3:0], link.ioIn} : {shiftIn[6:0], link.ioIn[0]};
  end

  logic wantsQuad;
  logic cmdAllowed;
  always_comb begin
    wantsQuad = (nextShift == fos_pkg::OP_QUAD_PP) || (nextShift == fos_pkg::OP_QUAD_PP4B);
    cmdAllowed = 1'b1;
    if (deepPowerDown || pdPending) begin
      cmdAllowed = (nextShift == fos_pkg::OP_RELEASE_PD) || (nextShift == fos_pkg::OP_RST_EN) ||
                   (nextShift == fos_pkg::OP_RST);
    end
    if (wantsQuad) begin
      cmdAllowed = cmdAllowed && !quadCmdMode && writeEnableLatch && quadEnable
                   && !writeInProgress && !(otpMode && lockBit);
    end
  end

  // Frame sequencing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= fos_pkg::ST_IDLE;
      opcode <= 8'h00;
      shiftIn <= 8'h00;
      bitCnt <= 6'd0;
      addr <= 32'h0;
      byteIdx <= 8'h00;
      byteCount <= 9'd0;
    end else if (link.csN) begin
      state <= fos_pkg::ST_IDLE;
    end else if (csFall) begin
      state <= fos_pkg::ST_OPCODE;
      bitCnt <= 6'd0;
      byteCount <= 9'd0;
      addr <= 32'h0;
    end else if (sclkRise) begin
      shiftIn <= nextShift;
      bitCnt <= bitCnt + 6'(nibStep);
      unique case (state)
        fos_pkg::ST_OPCODE: begin
          if (bitCnt + 6'(nibStep) == 6'd8) begin
            opcode <= nextShift;
            bitCnt <= 6'd0;
            if (!cmdAllowed) begin
              state <= fos_pkg::ST_SWALLOW;
            end else if (wantsQuad) begin
              state <= fos_pkg::ST_ADDR;
            end else if (nextShift == fos_pkg::OP_READ_SEC) begin
              state <= fos_pkg::ST_READOUT;
            end else begin
              state <= fos_pkg::ST_DONE;
            end
          end
        end
        fos_pkg::ST_ADDR: begin
          addr <= {addr[27:0], link.ioIn};
          if (bitCnt + 6'd4 == ((opcode == fos_pkg::OP_QUAD_PP4B) ? 6'd32 : addrBits)) begin
            state <= fos_pkg::ST_DATA;
            bitCnt <= 6'd0;
            byteIdx <= addr[3:0] == 4'h0 ? {addr[3:0], link.ioIn} : {addr[3:0], link.ioIn};
          end
        end
        fos_pkg::ST_DATA: begin
          if (bitCnt + 6'd4 == 6'd8) begin
            bitCnt <= 6'd0;
            byteIdx <= byteIdx + 8'h01;
            if (byteCount != 9'(fos_pkg::PAGE_BYTES)) begin
              byteCount <= byteCount + 9'd1;
            end
          end
        end
        fos_pkg::ST_DONE: begin
          state <= fos_pkg::ST_SWALLOW;
        end
        fos_pkg::ST_READOUT: begin
          bitCnt <= 6'd0;
        end
        fos_pkg::ST_SWALLOW: begin
          bitCnt <= 6'd0;
        end
        default: begin
          state <= fos_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Page buffer keeps the last bytes; wrap within the page
  always_ff @(posedge sys_clk) begin
    if (!link.csN && sclkRise && state == fos_pkg::ST_DATA && bitCnt + 6'd4 == 6'd8) begin
      pageBuf[byteIdx] <= nextShift;
    end
  end

  // Frame end decode: exact opcode boundary for single-byte commands
  logic frameOpEnd;
  logic frameProgEnd;
  assign frameOpEnd = csRise && (state == fos_pkg::ST_DONE || state == fos_pkg::ST_SWALLOW) &&
                      bitCnt == 6'd0 && state != fos_pkg::ST_SWALLOW;
  assign frameProgEnd = csRise && state == fos_pkg::ST_DATA && bitCnt == 6'd0 && byteCount != 9'd0;

  // Write enable latch and busy cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      writeEnableLatch <= 1'b0;
      writeInProgress <= 1'b0;
      progCnt <= 32'h0;
      progStart <= 1'b0;
      progAddr <= 32'h0;
      progProtected <= 1'b0;
      progIsOtp <= 1'b0;
    end else begin
      progStart <= 1'b0;
      if (frameOpEnd && opcode == fos_pkg::OP_WRITE_ENABLE_CMD) begin
        writeEnableLatch <= 1'b1;
      end else if (writeEnableSet) begin
        writeEnableLatch <= 1'b1;
      end
      if (frameProgEnd) begin
        writeInProgress <= !(!otpMode && isProtected(addr, blockProtect));
        progCnt <= 32'(PROG_CYCLES);
        progStart <= 1'b1;
        progAddr <= otpMode ? {23'h0, addr[8:0]} :
                    (opcode == fos_pkg::OP_QUAD_PP && !fourByteMode) ? {extAddrReg, addr[23:0]} : addr;
        progIsOtp <= otpMode;
        progProtected <= !otpMode && isProtected(addr, blockProtect);
      end else if (writeInProgress) begin
        if (progCnt <= 32'h1) begin
          writeInProgress <= 1'b0;
          writeEnableLatch <= 1'b0;
        end else begin
          progCnt <= progCnt - 32'h1;
        end
      end
      if (frameOpEnd && opcode == fos_pkg::OP_WRITE_SEC) begin
        writeEnableLatch <= 1'b0;
      end
    end
  end

  // OTP contents updated after an unprotected program while in OTP mode
  integer i;
  always_ff @(posedge sys_clk) begin
    if (writeInProgress && progCnt <= 32'h1 && progIsOtp && !lockBit && !factoryLock) begin
      for (i = 0; i < fos_pkg::PAGE_BYTES; i = i + 1) begin
        otpMem[{progAddr[8], 8'(i)}] <= otpMem[{progAddr[8], 8'(i)}] & pageBuf[i];
      end
    end
  end

  // Deep power-down, reset enable and OTP mode
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      deepPowerDown <= 1'b0;
      pdPending <= 1'b0;
      pdCnt <= 32'h0;
      resetArmed <= 1'b0;
      otpMode <= 1'b0;
    end else if (frameOpEnd) begin
      resetArmed <= (opcode == fos_pkg::OP_RST_EN);
      if (opcode == fos_pkg::OP_DEEP_PD && !deepPowerDown) begin
        pdPending <= 1'b1;
        pdCnt <= 32'(PD_ENTRY_CYCLES);
      end
      if (opcode == fos_pkg::OP_RELEASE_PD || (opcode == fos_pkg::OP_RST && resetArmed)) begin
        deepPowerDown <= 1'b0;
        pdPending <= 1'b0;
      end
      if (opcode == fos_pkg::OP_RST && resetArmed) begin
        otpMode <= 1'b0;
      end
      if (opcode == fos_pkg::OP_ENTER_OTP) begin
        otpMode <= 1'b1;
      end
      if (opcode == fos_pkg::OP_EXIT_OTP) begin
        otpMode <= 1'b0;
      end
    end else if (pdPending) begin
      if (pdCnt <= 32'h1) begin
        pdPending <= 1'b0;
        deepPowerDown <= 1'b1;
      end else begin
        pdCnt <= pdCnt - 32'h1;
      end
    end
  end

  // Security status flags; hardware set wins on coincident events
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      progFail <= 1'b0;
      eraseFail <= 1'b0;
      progSusp <= 1'b0;
      eraseSusp <= 1'b0;
      lockBit <= 1'b0;
      lockCaught <= 1'b0;
    end else begin
      if (!lockCaught) begin
        lockCaught <= 1'b1;
        lockBit <= lockNvIn;
      end else if (frameOpEnd && opcode == fos_pkg::OP_WRITE_SEC && writeEnableLatch) begin
        lockBit <= 1'b1;
      end
      if (progStart && progProtected) begin
        progFail <= 1'b1;
      end else if (writeInProgress && progCnt <= 32'h1) begin
        progFail <= progIsOtp && (lockBit || factoryLock);
      end
      if (coreEvt.eraseDone) begin
        eraseFail <= coreEvt.eraseFail;
      end
      if (coreEvt.progSuspend) begin
        progSusp <= 1'b1;
      end else if (coreEvt.progResume) begin
        progSusp <= 1'b0;
      end
      if (coreEvt.eraseSuspend) begin
        eraseSusp <= 1'b1;
      end else if (coreEvt.eraseResume) begin
        eraseSusp <= 1'b0;
      end
    end
  end

  always_comb begin
    securityStatus = fos_pkg::SEC_RESET;
    securityStatus[fos_pkg::BIT_FACTORY] = factoryLock;
    securityStatus[fos_pkg::BIT_LOCK] = lockBit;
    securityStatus[fos_pkg::BIT_PSUSP] = progSusp;
    securityStatus[fos_pkg::BIT_ESUSP] = eraseSusp;
    securityStatus[fos_pkg::BIT_PFAIL] = progFail;
    securityStatus[fos_pkg::BIT_EFAIL] = eraseFail;
  end

  // Security register readout, reloaded every byte, shifted on falling edges
  logic [2:0] outBit;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      outShift <= 8'h00;
      outBit <= 3'd0;
      readActive <= 1'b0;
    end else if (link.csN) begin
      readActive <= 1'b0;
    end else if (sclkFall && state == fos_pkg::ST_READOUT) begin
      if (!readActive || outBit == (quadCmdMode ? 3'd1 : 3'd7)) begin
        outShift <= securityStatus;
        outBit <= 3'd0;
        readActive <= 1'b1;
      end else begin
        outShift <= quadCmdMode ? {outShift[3:0], 4'h0} : {outShift[6:0], 1'b0};
        outBit <= outBit + 3'd1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ioOut <= 4'h0;
      ioOeN <= 4'hF;
    end else if (readActive && !link.csN) begin
      ioOut <= quadCmdMode ? outShift[7:4] : {2'b00, outShift[7], 1'b0};
      ioOeN <= quadCmdMode ? 4'h0 : 4'hD;
    end else begin
      ioOut <= 4'h0;
      ioOeN <= 4'hF;
    end
  end
endmodule
`default_nettype wire

// File: bench/fos_monitor.sv
// Concurrent checks on the sequencer ports.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fos_monitor #(
  parameter int PD_ENTRY_CYCLES = 20,
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched inputs
  input wire logic csN,
  input wire logic quadEnable,
  input wire logic quadCmdMode,
  input wire logic factoryLock,
  input wire fos_pkg::fos_core_evt_s coreEvt,
  // Watched outputs
  input wire logic writeEnableLatch,
  input wire logic writeInProgress,
  input wire logic deepPowerDown,
  input wire logic otpMode,
  input wire logic [7:0] securityStatus,
  input wire logic progStart,
  input wire logic progProtected
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  int csHigh;
  int wipCnt;
  // Cycles since deselect and length of the busy run
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      csHigh <= 0;
      wipCnt <= 0;
    end else begin
      csHigh <= csN ? csHigh + 1 : 0;
      wipCnt <= writeInProgress ? wipCnt + 1 : 0;
    end
  end
  sequence s_busy_run;
    writeInProgress [*8];
  endsequence
  a_prog_busy_start: assert property (progStart && !progProtected |-> ##[1:3] s_busy_run)
    else $error("busy did not follow program start");
  a_wip_run_bound: assert property (wipCnt <= PROG_CYCLES + 4)
    else $error("busy ran too long");
  a_wip_ends_wel: assert property ($fell(writeInProgress) |-> ##[0:2] !writeEnableLatch)
    else $error("write enable kept after program");
  a_prog_mode_ok: assert property (progStart |-> quadEnable && !quadCmdMode)
    else $error("program started in wrong mode");
  a_protect_no_busy: assert property (progStart && progProtected |-> !writeInProgress [*5])
    else $error("protected page went busy");
  a_pd_entry_delay: assert property ($rose(deepPowerDown) |-> csHigh >= PD_ENTRY_CYCLES)
    else $error("power-down entered too early");
  a_pd_ignores_otp: assert property (deepPowerDown && !otpMode |=> !otpMode)
    else $error("command acted in power-down");
  a_status_fixed_bits: assert property (!securityStatus[7] && !securityStatus[4] && securityStatus[0] == factoryLock)
    else $error("fixed status bits wrong");
  a_lock_sticky: assert property (securityStatus[1] |=> securityStatus[1])
    else $error("lock bit cleared");
  a_efail_track: assert property (coreEvt.eraseDone |=> securityStatus[6] == $past(coreEvt.eraseFail))
    else $error("erase fail flag wrong");
  a_psusp_set: assert property (coreEvt.progSuspend |=> securityStatus[2])
    else $error("program suspend flag not set");
endmodule
`default_nettype wire

// File: bench/fos_host.sv
// Host serial controller model: drives frames, samples read data.
// Assumes mode 0, half period of six system clocks.
`timescale 1ns/1ps
`default_nettype none
module fos_host (
  // Clock
  input wire logic sys_clk,
  // Pins toward the device
  output logic csN,
  output logic sclk,
  output logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOeN
);
  logic [3:0] drv = 4'h0;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
  end
  // Released lines show the last value while selected and its inverse while deselected; device wins where it drives
  assign ioIn = (ioOut & ~ioOeN) | ((csN ? ~drv : drv) & ioOeN);
  task automatic unit(input logic [3:0] v, output logic so);
    drv <= v;
    repeat (6) @(posedge sys_clk);
    so = ioOut[1];
    sclk <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sclk <= 1'b0;
  endtask
  // One frame: units on rising edges, then nRead sampled bits
  task automatic frame(input logic [3:0] u[$], input int nRead, output logic [15:0] rd);
    logic b;
    rd = 16'h0000;
    @(posedge sys_clk);
    csN <= 1'b0;
    repeat (6) @(posedge sys_clk);
    foreach (u[i]) unit(u[i], b);
    for (int i = 0; i < nRead; i++) begin
      unit(4'h0, b);
      rd = {rd[14:0], b};
    end
    repeat (6) @(posedge sys_clk);
    csN <= 1'b1;
    repeat (16) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the command sequencer.
// Assumes the host model and the bind below.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PDC = 20;
  localparam int PGC = 600;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic csN, sclk, writeEnableSet, factoryLock;
  logic quadEnable = 1'b1;
  logic quadCmdMode = 1'b0;
  logic [3:0] blockProtect = 4'h0;
  logic [3:0] ioIn, ioOut, ioOeN;
  fos_pkg::fos_core_evt_s coreEvt = '0;
  logic writeEnableLatch, writeInProgress, deepPowerDown, otpMode, progStart, progProtected;
  logic [7:0] securityStatus;
  logic [31:0] progAddr, seenAddr;
  logic [7:0] extAddr = 8'h00;
  logic seenProt = 1'b0;
  logic [15:0] rdBack;
  logic ef = 1'b0, pf = 1'b0, es = 1'b0, ps = 1'b0, lock = 1'b0;
  int n_errors = 0, n_tests = 0, progCount = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  fos_host u_fos_host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN));
  fos_sequencer #(.PD_ENTRY_CYCLES(PDC), .PROG_CYCLES(PGC)) u_fos_sequencer (
    .sys_clk(sys_clk), .nrst(nrst), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN),
    .quadEnable(quadEnable), .quadCmdMode(quadCmdMode), .fourByteMode(1'b0), .extAddrReg(extAddr),
    .blockProtect(blockProtect), .factoryLock(factoryLock), .lockNvIn(1'b0), .writeEnableSet(writeEnableSet),
    .coreEvt(coreEvt), .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
    .deepPowerDown(deepPowerDown), .otpMode(otpMode), .securityStatus(securityStatus),
    .progStart(progStart), .progAddr(progAddr), .progProtected(progProtected));
  always @(posedge sys_clk) begin
    if (progStart) begin
      progCount++;
      seenAddr = progAddr;
      seenProt = progProtected;
    end
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_status();
    return {1'b0, ef, pf, 1'b0, es, ps, lock, factoryLock};
  endfunction
  // Opcode units; upper lines carry noise in single-line mode
  function automatic void add_op(inout logic [3:0] q[$], input logic [7:0] op);
    if (quadCmdMode) begin
      q.push_back(op[7:4]);
      q.push_back(op[3:0]);
    end else begin
      for (int i = 7; i >= 0; i--) q.push_back({3'($urandom), op[i]});
    end
  endfunction
  task automatic cmd(input logic [7:0] op, input int extra, input int nRead);
    logic [3:0] q[$];
    add_op(q, op);
    repeat (extra) q.push_back(4'($urandom));
    u_fos_host.frame(q, nRead, rdBack);
  endtask
  task automatic quad_prog(input logic [31:0] adr, input int nb, input logic wide);
    logic [3:0] q[$];
    add_op(q, wide ? fos_pkg::OP_QUAD_PP4B : fos_pkg::OP_QUAD_PP);
    for (int i = wide ? 7 : 5; i >= 0; i--) q.push_back(adr[i*4+:4]);
    repeat (2 * nb) q.push_back(4'($urandom));
    u_fos_host.frame(q, 0, rdBack);
  endtask
  task automatic pulse_wel();
    @(posedge sys_clk);
    writeEnableSet <= 1'b1;
    @(posedge sys_clk);
    writeEnableSet <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  initial begin
    logic [5:0] ev;
    logic [31:0] adr;
    int pc;
    void'($urandom(90467));
    factoryLock = 1'($urandom);
    writeEnableSet = 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("status", securityStatus, exp_status());
    check("pdown", deepPowerDown, 0);
    for (int m = 0; m < 2; m++) begin
      quadCmdMode <= 1'(m);
      @(posedge sys_clk);
      cmd(fos_pkg::OP_ENTER_OTP, 0, 0);
      check("otp", otpMode, 1);
      cmd(fos_pkg::OP_EXIT_OTP, 0, 0);
      check("otp", otpMode, 0);
    end
    quadCmdMode <= 1'b0;
    @(posedge sys_clk);
    cmd(fos_pkg::OP_DEEP_PD, 1, 0);
    repeat (PDC + 10) @(posedge sys_clk);
    check("pdown", deepPowerDown, 0);
    for (int r = 0; r < 2; r++) begin
      cmd(fos_pkg::OP_DEEP_PD, 0, 0);
      check("pdown", deepPowerDown, 0);
      repeat (10) @(posedge sys_clk);
      check("pdown", deepPowerDown, 1);
      cmd(fos_pkg::OP_ENTER_OTP, 0, 0);
      check("otp", otpMode, 0);
      if (r == 0) begin
        cmd(fos_pkg::OP_RELEASE_PD, 0, 0);
      end else begin
        cmd(fos_pkg::OP_RST_EN, 0, 0);
        cmd(fos_pkg::OP_RST, 0, 0);
      end
      check("pdown", deepPowerDown, 0);
    end
    for (int i = 0; i < 12; i++) begin
      ev = ($urandom % 6 == 4) ? 6'h30 : 6'h01 << ($urandom % 6);
      @(posedge sys_clk);
      coreEvt <= fos_pkg::fos_core_evt_s'(ev);
      @(posedge sys_clk);
      coreEvt <= '0;
      if (ev[5]) ef = ev[4];
      if (ev[3]) es = 1'b1;
      if (ev[2]) es = 1'b0;
      if (ev[1]) ps = 1'b1;
      if (ev[0]) ps = 1'b0;
      repeat (3) @(posedge sys_clk);
      check("status", securityStatus, exp_status());
    end
    // Refusals: no latch, no quad enable, quad mode; protected; then good three- and four-byte ones
    for (int c = 0; c < 6; c++) begin
      adr = $urandom;
      extAddr <= 8'($urandom);
      quadEnable <= (c != 1);
      quadCmdMode <= (c == 2);
      blockProtect <= (c == 3) ? 4'hF : 4'h0;
      if (c == 1) cmd(fos_pkg::OP_WRITE_ENABLE_CMD, 0, 0);
      else if (c != 0) pulse_wel();
      check("wel", writeEnableLatch, c != 0);
      pc = progCount;
      quad_prog(adr, 1 + $urandom % 3, c == 5);
      check("start", progCount - pc, c >= 3);
      check("busy", writeInProgress, c >= 4);
      if (c == 3) pf = 1'b1;
      if (c >= 3) check("prot", seenProt, c == 3);
      if (c == 3) check("pfail", securityStatus[5], 1);
      if (c >= 4) begin
        check("addr", seenAddr, (c == 5) ? adr : {extAddr, adr[23:0]});
        cmd(fos_pkg::OP_READ_SEC, 0, 16);
        check("secread", rdBack & 16'hDFDF, {2{exp_status()}} & 16'hDFDF);
        check("busy", writeInProgress, 1);
        for (int t = 0; t < 2000 && writeInProgress; t++) @(posedge sys_clk);
        pf = 1'b0;
        check("wel", writeEnableLatch, 0);
        check("status", securityStatus, exp_status());
      end
    end
    cmd(fos_pkg::OP_WRITE_SEC, 0, 0);
    check("lock", securityStatus[1], 0);
    pulse_wel();
    cmd(fos_pkg::OP_WRITE_SEC, 3, 0);
    check("lock", securityStatus[1], 0);
    pulse_wel();
    cmd(fos_pkg::OP_WRITE_SEC, 0, 0);
    lock = 1'b1;
    check("status", securityStatus, exp_status());
    check("wel", writeEnableLatch, 0);
    cmd(fos_pkg::OP_ENTER_OTP, 0, 0);
    pulse_wel();
    pc = progCount;
    quad_prog(32'h0000_0010, 1, 1'b0);
    check("start", progCount - pc, 0);
    cmd(fos_pkg::OP_EXIT_OTP, 0, 0);
    check("lock", securityStatus[1], 1);
    end_of_test();
  end
endmodule
bind fos_sequencer fos_monitor #(.PD_ENTRY_CYCLES(PD_ENTRY_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_fos_monitor (
  .sys_clk(sys_clk), .nrst(nrst), .csN(csN), .quadEnable(quadEnable), .quadCmdMode(quadCmdMode),
  .factoryLock(factoryLock), .coreEvt(coreEvt), .writeEnableLatch(writeEnableLatch),
  .writeInProgress(writeInProgress), .deepPowerDown(deepPowerDown), .otpMode(otpMode),
  .securityStatus(securityStatus), .progStart(progStart), .progProtected(progProtected));
`default_nettype wire
